// ===== hw/static_mem_cs_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - optimisation off: full float gap before next access
// - optimisation on: float overlaps next setup phase
// - float time field bits 19:16, 0 to 15
// - bus held float time plus one cycle
// - bit 12 selects 8 or 16 bit bus
// - byte access type used only on 16 bits
// - type 0: one write strobe plus lane selects
// - type 1: split write strobes, reads no lanes
// - wait input sampled only in pulse phase
// - wait mode 0 ignores wait, 1 reserved
// - wait mode 2 freezes access in place
// - wait mode 3 extends pulse end while low
// - write mode 0: chip select controls writes
module static_mem_cs_mode_control
  import smc_mode_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic [31:0] mode_word_in,
  input  wire logic [3:0]  setup_cycles_in,
  input  wire logic [3:0]  pulse_cycles_in,
  input  wire logic [3:0]  hold_cycles_in,
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic [1:0]  req_byte_en_in,
  input  wire logic        ext_wait_n_in,
  output logic             req_ready_out,
  output logic             done_out,
  output logic             bus_busy_out,
  output logic             chip_sel_n_out,
  output logic             rd_strobe_n_out,
  output logic             wr_strobe_n_out,
  output logic             lane0_sel_n_out,
  output logic             lane1_sel_n_out,
  output logic             wr_low_n_out,
  output logic             wr_high_n_out
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [3:0] phase_load(input logic [3:0] n);
    phase_load = (n == PHASE_LAST) ? PHASE_LAST : (n - CNT_ONE);
  endfunction : phase_load

  function automatic logic is_active(input phase_t st);
    is_active = (st != ST_IDLE);
  endfunction : is_active

  // ************************************************************
  // mode word fields
  // ************************************************************
  logic       write_ctrl_wr;
  logic [1:0] wait_mode;
  logic       byte_access_type;
  logic       bus_width_sel;
  logic [3:0] float_cycle_count;
  logic       float_opt;
  logic       split_mode;

  assign write_ctrl_wr     = mode_word_in[WMODE_BIT];
  assign wait_mode         = mode_word_in[WAIT_MSB:WAIT_LSB];
  assign byte_access_type  = mode_word_in[BYTE_TYPE_BIT];
  assign bus_width_sel     = mode_word_in[WIDTH_BIT];
  assign float_cycle_count = mode_word_in[FLOAT_MSB:FLOAT_LSB];
  assign float_opt         = mode_word_in[FLOAT_OPT_BIT];
  assign split_mode        = bus_width_sel & byte_access_type;

  // ************************************************************
  // state
  // ************************************************************
  phase_t     state_q;
  phase_t     state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       wr_q;
  logic [1:0] be_q;
  logic       done_q;
  logic       float_busy;
  logic [4:0] float_remain;

  // ************************************************************
  // phase decode
  // ************************************************************
  logic accept;
  logic setup_go;
  logic wait_frozen;
  logic wait_extend;
  logic pulse_go;
  logic hold_go;
  logic float_load;
  logic cnt_last;

  assign cnt_last      = (cnt_q == PHASE_LAST);
  assign req_ready_out = (state_q == ST_IDLE)
                       & (float_opt | ~float_busy);
  assign accept        = req_ready_out & req_valid_in;
  assign setup_go      = (state_q == ST_SETUP) & cnt_last
                       & ~float_busy;
  assign wait_frozen   = (state_q == ST_PULSE)
                       & (wait_mode == WAIT_FROZEN)
                       & ~ext_wait_n_in;
  assign wait_extend   = (state_q == ST_PULSE) & cnt_last
                       & (wait_mode == WAIT_READY)
                       & ~ext_wait_n_in;
  assign pulse_go      = (state_q == ST_PULSE) & cnt_last
                       & ~wait_frozen & ~wait_extend;
  assign hold_go       = (state_q == ST_HOLD) & cnt_last;
  assign float_load    = pulse_go & ~wr_q;

  // ************************************************************
  // next phase
  // ************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_SETUP;
          cnt_d   = phase_load(setup_cycles_in);
        end
      end
      ST_SETUP: begin
        if (setup_go) begin
          state_d = ST_PULSE;
          cnt_d   = phase_load(pulse_cycles_in);
        end else if (!cnt_last) begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ST_PULSE: begin
        if (pulse_go) begin
          state_d = ST_HOLD;
          cnt_d   = phase_load(hold_cycles_in);
        end else if (!wait_frozen && !cnt_last) begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ST_HOLD: begin
        if (hold_go) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // strobe selection
  // ************************************************************
  logic       acc_wr;
  logic [1:0] acc_be;
  logic       act_d;
  logic       ctl_d;
  logic       wr_time;
  logic       cs_on;
  logic       rd_on;
  logic       wr_on;
  logic [1:0] lane_on;
  logic [1:0] split_on;

  assign acc_wr   = accept ? req_write_in : wr_q;
  assign acc_be   = accept ? req_byte_en_in : be_q;
  assign act_d    = is_active(state_d);
  assign ctl_d    = (state_d == ST_PULSE);
  assign wr_time  = write_ctrl_wr ? ctl_d : act_d;
  assign cs_on    = act_d
                  & ((acc_wr & ~write_ctrl_wr) ? ctl_d : 1'b1);
  assign rd_on    = ~acc_wr & ctl_d;
  assign wr_on    = acc_wr & ~split_mode & wr_time;
  assign lane_on  = {2{act_d & bus_width_sel & ~byte_access_type}}
                  & acc_be;
  assign split_on = {2{acc_wr & split_mode & wr_time}}
                  & acc_be;

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      cnt_q   <= PHASE_LAST;
      wr_q    <= 1'b0;
      be_q    <= 2'h0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      wr_q    <= acc_wr;
      be_q    <= acc_be;
      done_q  <= hold_go;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      chip_sel_n_out  <= 1'b1;
      rd_strobe_n_out <= 1'b1;
      wr_strobe_n_out <= 1'b1;
      lane0_sel_n_out <= 1'b1;
      lane1_sel_n_out <= 1'b1;
      wr_low_n_out    <= 1'b1;
      wr_high_n_out   <= 1'b1;
    end else begin
      chip_sel_n_out  <= ~cs_on;
      rd_strobe_n_out <= ~rd_on;
      wr_strobe_n_out <= ~wr_on;
      lane0_sel_n_out <= ~lane_on[0];
      lane1_sel_n_out <= ~lane_on[1];
      wr_low_n_out    <= ~split_on[0];
      wr_high_n_out   <= ~split_on[1];
    end
  end

  // ************************************************************
  // float gap
  // ************************************************************
  float_gap_counter u_float (
    .mclk_in    (mclk_in),
    .resetn_in  (resetn_in),
    .load_in    (float_load),
    .cycles_in  (float_cycle_count),
    .busy_out   (float_busy),
    .remain_out (float_remain)
  );

  assign bus_busy_out = float_busy;
  assign done_out     = done_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence read_pulse_end;
    pulse_go && !wr_q;
  endsequence

  sequence float_started;
    rd_strobe_n_out && bus_busy_out;
  endsequence

  sequence ready_stall;
    (state_q == ST_PULSE) && cnt_last && (wait_mode == WAIT_READY)
      && !ext_wait_n_in;
  endsequence

  full_gap_a: assert property (
    (!float_opt && $rose(state_q == ST_SETUP)) |-> !float_busy)
    else $error("access began inside float gap");

  overlap_setup_a: assert property (
    (state_q == ST_SETUP && float_busy) |=> state_q != ST_PULSE)
    else $error("pulse began before float gap ended");

  opt_ready_a: assert property (
    (float_opt && state_q == ST_IDLE && float_busy) |-> req_ready_out)
    else $error("optimised mode refused access during float");

  float_len_a: assert property (
    read_pulse_end |=> float_remain == $past(float_cycle_count) + 5'h01)
    else $error("float count not float time plus one");

  turnaround_a: assert property (
    read_pulse_end |=> float_started)
    else $error("bus not held after read strobe rise");

  narrow_bus_a: assert property (
    !bus_width_sel |=> lane1_sel_n_out && wr_high_n_out)
    else $error("high lane driven on 8 bit bus");

  narrow_type_a: assert property (
    (!bus_width_sel && acc_wr && ctl_d) |=> !wr_strobe_n_out
      && wr_low_n_out)
    else $error("byte access type used on 8 bit bus");

  byte_select_a: assert property (
    (bus_width_sel && !byte_access_type && ctl_d && acc_be[0])
      |=> !lane0_sel_n_out && !chip_sel_n_out)
    else $error("lane select missing in byte select mode");

  byte_write_a: assert property (
    (split_mode && !acc_wr && act_d) |=> lane0_sel_n_out
      && lane1_sel_n_out && wr_strobe_n_out)
    else $error("lane or write strobe on byte write read");

  hold_no_wait_a: assert property (
    (state_q == ST_HOLD && !cnt_last) |=> state_q == ST_HOLD
      && cnt_q == $past(cnt_q) - 4'h1)
    else $error("hold phase did not count down");

  wait_off_a: assert property (
    (state_q == ST_PULSE && cnt_last && !wait_mode[1])
      |=> state_q == ST_HOLD)
    else $error("wait honoured while disabled");

  frozen_a: assert property (
    (state_q == ST_PULSE && wait_mode == WAIT_FROZEN && !ext_wait_n_in)
      |=> state_q == ST_PULSE && $stable(cnt_q))
    else $error("frozen access moved");

  ready_a: assert property (
    ready_stall |=> state_q == ST_PULSE && cnt_last)
    else $error("ready mode ended pulse while wait low");

  cs_ctrl_a: assert property (
    (state_d == ST_SETUP && acc_wr && !write_ctrl_wr)
      |=> chip_sel_n_out && (split_mode || !wr_strobe_n_out))
    else $error("chip select not controlling write");

  we_ctrl_a: assert property (
    (state_d == ST_SETUP && acc_wr && write_ctrl_wr && !split_mode)
      |=> !chip_sel_n_out && wr_strobe_n_out)
    else $error("write strobe not controlling write");

endmodule : static_mem_cs_mode_control

`default_nettype wire

// ===== hw/smc_mode_pkg.sv
package smc_mode_pkg;

  // ************************************************************
  // mode word field positions
  // ************************************************************
  localparam int WMODE_BIT     = 1;
  localparam int WAIT_LSB      = 4;
  localparam int WAIT_MSB      = 5;
  localparam int BYTE_TYPE_BIT = 8;
  localparam int WIDTH_BIT     = 12;
  localparam int FLOAT_LSB     = 16;
  localparam int FLOAT_MSB     = 19;
  localparam int FLOAT_OPT_BIT = 20;

  // ************************************************************
  // wait mode encodings
  // ************************************************************
  localparam logic [1:0] WAIT_OFF    = 2'h0;
  localparam logic [1:0] WAIT_RSVD   = 2'h1;
  localparam logic [1:0] WAIT_FROZEN = 2'h2;
  localparam logic [1:0] WAIT_READY  = 2'h3;

  // ************************************************************
  // counter constants
  // ************************************************************
  localparam logic [3:0] PHASE_LAST = 4'h0;
  localparam logic [3:0] CNT_ONE    = 4'h1;
  localparam logic [4:0] FLOAT_IDLE = 5'h00;
  localparam logic [4:0] FLOAT_TURN = 5'h01;
  localparam logic [4:0] FLOAT_STEP = 5'h01;

  // ************************************************************
  // access phases
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD
  } phase_t;

endpackage : smc_mode_pkg

// ===== hw/float_gap_counter.sv
`timescale 1ns/1ps
`default_nettype none

module float_gap_counter
  import smc_mode_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       load_in,
  input  wire logic [3:0] cycles_in,
  output logic            busy_out,
  output logic      [4:0] remain_out
);

  // ************************************************************
  // float time plus one turnaround cycle
  // ************************************************************
  logic [4:0] remain_q;
  logic [4:0] remain_d;

  assign remain_d = load_in ? ({1'b0, cycles_in} + FLOAT_TURN)
                  : (remain_q != FLOAT_IDLE) ? (remain_q - FLOAT_STEP)
                  : FLOAT_IDLE;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      remain_q <= FLOAT_IDLE;
    end else begin
      remain_q <= remain_d;
    end
  end

  assign remain_out = remain_q;
  assign busy_out   = (remain_q != FLOAT_IDLE);

endmodule : float_gap_counter

`default_nettype wire

// ===== bench/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// external memory: holds wait low at the start of a strobe
// ************************************************************
module ext_mem_model (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       strobe_n_in,
  input  wire logic [3:0] stall_in,
  output logic            ext_wait_n_out
);
  logic [3:0] k_q;

  // pull-up level whenever no strobe is active
  assign ext_wait_n_out = strobe_n_in | (k_q >= stall_in);

  always_ff @(posedge mclk_in) begin
    if (!resetn_in || strobe_n_in) begin
      k_q <= 4'h0;
    end else if (k_q != 4'hf) begin
      k_q <= k_q + 4'h1;
    end
  end
endmodule : ext_mem_model

`default_nettype wire

// ===== bench/tb_static_mem_cs_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_static_mem_cs_mode_control;
  import smc_mode_pkg::*;

  logic        mclk, resetn, req_valid, req_write, ext_wait_n;
  logic [31:0] mw;
  logic [3:0]  s_c, p_c, h_c, stall;
  logic [1:0]  be;
  logic        req_ready_out, done_out, bus_busy_out;
  logic        cs_n, rd_n, wr_n, l0_n, l1_n, wl_n, wh_n;
  logic [7:0]  pins;
  int          err_count, checks, cyc, lowc[8], seed;
  bit          mon;

  static_mem_cs_mode_control i_dut (
    .mclk_in(mclk), .resetn_in(resetn), .mode_word_in(mw),
    .setup_cycles_in(s_c), .pulse_cycles_in(p_c),
    .hold_cycles_in(h_c), .req_valid_in(req_valid),
    .req_write_in(req_write), .req_byte_en_in(be),
    .ext_wait_n_in(ext_wait_n), .req_ready_out(req_ready_out),
    .done_out(done_out), .bus_busy_out(bus_busy_out),
    .chip_sel_n_out(cs_n), .rd_strobe_n_out(rd_n),
    .wr_strobe_n_out(wr_n), .lane0_sel_n_out(l0_n),
    .lane1_sel_n_out(l1_n), .wr_low_n_out(wl_n),
    .wr_high_n_out(wh_n));

  ext_mem_model i_mem (
    .mclk_in(mclk), .resetn_in(resetn),
    .strobe_n_in(rd_n & wr_n & wl_n & wh_n), .stall_in(stall),
    .ext_wait_n_out(ext_wait_n));

  assign pins = {!bus_busy_out, wh_n, wl_n, l1_n, l0_n, wr_n, rd_n, cs_n};

  // ************************************************************
  // checking and closing
  // ************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp,
           input string m);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s seen %0h exp %0h", $time, m, seen, exp);
    end
  endtask : chk

  task complete_run;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  function int mx(input logic [3:0] v);
    return (v == 4'h0) ? 1 : int'(v);
  endfunction : mx

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      $display("MISMATCH %0t timeout", $time);
      complete_run();
    end
  end

  // low-cycle counters and gap watch
  always @(negedge mclk) begin
    if (mon) begin
      for (int i = 0; i < 8; i++) lowc[i] += int'(!pins[i]);
    end
    if (resetn && bus_busy_out === 1'b1) begin
      chk(rd_n, 1'b1, "strobe in gap");
      if (!mw[FLOAT_OPT_BIT]) begin
        chk(req_ready_out, 1'b0, "ready in gap");
      end
    end
  end

  // ************************************************************
  // one access with expectations
  // ************************************************************
  task acc(input logic [31:0] m, input logic [3:0] s, p, h,
           input logic w, input logic [1:0] b, input logic [3:0] st,
           input bit ovl);
    int n, pp, sph, ext, off, ws;
    logic ba, wb, tb, wm;
    @(posedge mclk);
    mw <= m;
    s_c <= s;
    p_c <= p;
    h_c <= h;
    stall <= st;
    req_valid <= 1'b1;
    req_write <= w;
    be <= b;
    do @(negedge mclk); while (req_ready_out !== 1'b1);
    ba = bus_busy_out;
    @(posedge mclk);
    req_valid <= 1'b0;
    lowc = '{default:0};
    mon = 1'b1;
    n = 0;
    do begin @(negedge mclk); n++; end while (done_out !== 1'b1 && n < 99);
    wb = m[WIDTH_BIT];
    tb = m[BYTE_TYPE_BIT];
    wm = m[WMODE_BIT];
    // wait follows the strobe, which leads from setup on select writes
    off = (w && !wm) ? mx(s) : 0;
    ws = (w && wb && tb && b == 2'h0) ? 0 : int'(st);
    ext = 0;
    if (m[WAIT_MSB:WAIT_LSB] == WAIT_FROZEN && ws > off)
      ext = ws - off;
    if (m[WAIT_MSB:WAIT_LSB] == WAIT_READY && ws >= off + mx(p))
      ext = ws + 1 - off - mx(p);
    pp = mx(p) + ext;
    sph = mx(s) + pp + mx(h);
    chk(done_out, 1'b1, "done");
    if (!ba) chk(n, sph + 1, "latency");
    chk(lowc[0], (w && !wm) ? pp : sph, "select");
    chk(lowc[1], w ? 0 : pp, "read strobe");
    if (!(w && wb && tb))
      chk(lowc[2], w ? (wm ? pp : sph) : 0, "write strobe");
    chk(lowc[3] != 0, wb && !tb && b[0], "lane0");
    chk(lowc[4] != 0, wb && !tb && b[1], "lane1");
    chk(lowc[5] != 0, w && wb && tb && b[0], "low write");
    chk(lowc[6] != 0, w && wb && tb && b[1], "high write");
    if (ovl) begin
      chk(req_ready_out, 1'b1, "overlap ready");
    end else begin
      while (bus_busy_out === 1'b1 && n < 199) begin
        @(negedge mclk);
        n++;
      end
      if (!w) begin
        chk(lowc[7], int'(m[FLOAT_MSB:FLOAT_LSB]) + 1, "gap");
      end
    end
    mon = 1'b0;
  endtask : acc

  initial begin
    logic [31:0] m;
    logic        w;
    mw = 32'h0;
    s_c = 4'h1;
    p_c = 4'h1;
    h_c = 4'h1;
    stall = 4'h0;
    req_valid = 1'b0;
    req_write = 1'b0;
    be = 2'h3;
    resetn = 1'b0;
    seed = 32'hc419;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk(req_ready_out, 1'b1, "reset ready");
    chk(cs_n, 1'b1, "reset select");
    chk(done_out, 1'b0, "reset done");
    acc(32'h000f_1000, 4'h0, 4'h1, 4'h1, 1'b0, 2'h3, 4'h0, 1'b0);
    acc(32'h0010_1000, 4'h1, 4'h1, 4'h1, 1'b0, 2'h1, 4'h0, 1'b0);
    acc(32'h001f_1100, 4'h2, 4'h1, 4'h1, 1'b0, 2'h3, 4'h0, 1'b1);
    acc(32'h001f_1100, 4'h2, 4'h2, 4'h1, 1'b1, 2'h2, 4'h0, 1'b0);
    for (int i = 0; i < 48; i++) begin
      m = $random(seed);
      m[WAIT_MSB:WAIT_LSB] = 2'(i);
      w = $random(seed);
      // hold of at least one cycle whenever wait is in use
      acc(m, 4'($random(seed) & 3), 4'($random(seed) & 3),
          4'h1 + 4'($random(seed) & 3), w, 2'($random(seed)),
          4'($random(seed) & 7), 1'b0);
    end
    complete_run();
  end
endmodule : tb_static_mem_cs_mode_control

`default_nettype wire
